// ### hw/crc32_defs.vh
`ifndef CRC32_DEFS_VH
`define CRC32_DEFS_VH
// ----------------------------------------
// register map (byte offsets)
// ----------------------------------------
`define OFS_CHECKSUM_DATA_PORT 4'h0
`define OFS_SCRATCH_BYTE 4'h4
`define OFS_CHECKSUM_CONTROL 4'h8
// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define CHECKSUM_RESET 32'hffffffff
`define SCRATCH_RESET 8'h00
`define CTRL_REINIT_BIT 0
`define CRC_POLY 32'h04c11db7
// ----------------------------------------
// timing
// ----------------------------------------
`define CRC_CYCLES 4
`endif

// ### hw/crc_buffer.v
`timescale 1ns/10ps
// ----------------------------------------
// two-entry skid buffer for incoming data words
// ----------------------------------------
module crc_buffer #(
    parameter WIDTH = 32
) (
    input wire clk,
    input wire rst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:1];
    reg wr_ptr;
    reg rd_ptr;
    reg [1:0] count;
    wire push;
    wire pop;
    assign in_ready = (count != 2'd2);
    assign out_valid = (count != 2'd0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always @(posedge clk) begin
        if (rst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'd0;
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr <= ~wr_ptr;
            end
            if (pop)
                rd_ptr <= ~rd_ptr;
            if (push && !pop)
                count <= count + 2'd1;
            else if (pop && !push)
                count <= count - 2'd1;
        end
    end
endmodule // crc_buffer

// ### hw/crc32_word_accumulator.v
`timescale 1ns/10ps
`include "crc32_defs.vh"
module crc32_word_accumulator #(
    parameter CYCLES = `CRC_CYCLES
) (
    input wire clk,
    input wire rst,
    input wire sel,
    input wire write,
    input wire [3:0] addr,
    input wire [31:0] wdata,
    output reg [31:0] rdata,
    output reg ready,
    output reg busy
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_CALC = 1'b1;
    localparam [2:0] CNT_FIRST = 3'd1;
    localparam [2:0] CNT_LAST = CYCLES - 1;
    localparam [31:0] POLY = `CRC_POLY;
    reg state;
    reg next_state;
    reg [31:0] checksum_value;
    reg [31:0] next_checksum;
    reg [31:0] word_in;
    reg [31:0] next_word_in;
    reg [2:0] cnt;
    reg [2:0] next_cnt;
    reg [7:0] scratch_value;
    reg reinit_pending;
    reg next_reinit_pending;
    reg next_ready;
    reg next_busy;
    reg [31:0] next_rdata;
    wire buf_in_ready;
    wire buf_valid;
    wire [31:0] buf_data;
    wire take;
    wire accept;
    wire wr_req;
    wire rd_req;
    wire data_wr;
    wire scratch_wr;
    wire ctrl_wr;
    wire reinit_req;
    wire settled;
    wire [31:0] next_crc;
    wire [31:0] chain [0:32];
    wire [31:0] shifted [0:31];

    // ----------------------------------------
    // request decode
    // ----------------------------------------
    assign accept = sel && ready;
    assign wr_req = accept && write;
    assign rd_req = accept && !write;
    assign data_wr = wr_req && (addr == `OFS_CHECKSUM_DATA_PORT);
    assign scratch_wr = wr_req && (addr == `OFS_SCRATCH_BYTE);
    assign ctrl_wr = wr_req && (addr == `OFS_CHECKSUM_CONTROL);
    assign reinit_req = ctrl_wr && wdata[`CTRL_REINIT_BIT];
    assign take = buf_valid && (state == ST_IDLE) && !reinit_pending;
    assign settled = (state == ST_IDLE) && !buf_valid && !reinit_pending;

    // ----------------------------------------
    // input buffer: stall reaches the bus via ready
    // ----------------------------------------
    crc_buffer #(.WIDTH(32)) u_buf (
        .clk(clk),
        .rst(rst),
        .in_valid(data_wr && ready),
        .in_ready(buf_in_ready),
        .in_data(wdata),
        .out_valid(buf_valid),
        .out_ready(take),
        .out_data(buf_data)
    );

    // ----------------------------------------
    // whole-word crc step, msb first
    // ----------------------------------------
    genvar g;
    assign chain[0] = checksum_value ^ word_in;
    generate
        for (g = 0; g < 32; g = g + 1) begin : g_bit
            assign shifted[g] = {chain[g][30:0], 1'b0};
            assign chain[g + 1] = chain[g][31] ? (shifted[g] ^ POLY) : shifted[g];
        end
    endgenerate
    assign next_crc = chain[32];

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always @* begin
        next_state = state;
        next_checksum = checksum_value;
        next_word_in = word_in;
        next_cnt = cnt;
        next_reinit_pending = reinit_pending;
        case (state)
            ST_IDLE: begin
                if (reinit_pending) begin
                    next_checksum = `CHECKSUM_RESET;
                    next_reinit_pending = 1'b0;
                end else if (take) begin
                    next_word_in = buf_data;
                    next_cnt = CNT_FIRST;
                    next_state = ST_CALC;
                end
            end
            ST_CALC: begin
                if (cnt == CNT_LAST) begin
                    next_checksum = next_crc;
                    next_state = ST_IDLE;
                end
                next_cnt = cnt + 3'd1;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // a fresh request outweighs the clear of the same cycle
        if (reinit_req) begin
            next_reinit_pending = 1'b1;
        end
    end

    // ----------------------------------------
    // handshake
    // ----------------------------------------
    always @* begin
        // any taken access costs one low cycle, a reinitialise two; a data word keeps ready low until folded in
        next_ready = !accept && buf_in_ready && settled;
    end

    // ----------------------------------------
    // busy flag
    // ----------------------------------------
    always @* begin
        next_busy = (state == ST_CALC) || buf_valid || reinit_pending || data_wr
            || reinit_req;
    end

    // ----------------------------------------
    // read data select
    // ----------------------------------------
    always @* begin
        next_rdata = rdata;
        if (rd_req) begin
            case (addr)
                `OFS_CHECKSUM_DATA_PORT: begin
                    next_rdata = checksum_value;
                end
                `OFS_SCRATCH_BYTE: begin
                    next_rdata = {24'h000000, scratch_value};
                end
                default: begin
                    next_rdata = 32'h00000000;
                end
            endcase
        end
    end

    // ----------------------------------------
    // state registers
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
            checksum_value <= `CHECKSUM_RESET;
            word_in <= 32'h00000000;
            cnt <= 3'd0;
            reinit_pending <= 1'b0;
        end else begin
            state <= next_state;
            checksum_value <= next_checksum;
            word_in <= next_word_in;
            cnt <= next_cnt;
            reinit_pending <= next_reinit_pending;
        end
    end

    // ----------------------------------------
    // scratch byte, untouched by a reinitialise
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            scratch_value <= `SCRATCH_RESET;
        end else if (scratch_wr) begin
            scratch_value <= wdata[7:0];
        end
    end

    // ----------------------------------------
    // bus outputs, all registered
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            ready <= 1'b1;
            busy <= 1'b0;
            rdata <= 32'h00000000;
        end else begin
            ready <= next_ready;
            busy <= next_busy;
            rdata <= next_rdata;
        end
    end
endmodule // crc32_word_accumulator

// ### sim/crc32_word_accumulator_properties.sv
`timescale 1ns/10ps
module crc32_props(
    input wire clk,
    input wire rst,
    input wire sel,
    input wire write,
    input wire [3:0] addr,
    input wire [31:0] wdata,
    input wire [31:0] rdata,
    input wire ready,
    input wire busy
);
    wire tk = sel && ready;
    wire rd = tk && !write;
    wire dw = tk && write && addr == 4'h0;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_ready_drop: assert property (tk |=> !ready) else $error("ready held");
    a_write_busy: assert property (dw |=> busy) else $error("no busy");
    a_update_bound: assert property (dw |-> ##[2:8] ready) else $error("slow update");
    a_reinit_bound: assert property (tk && write && addr == 4'h8 && wdata[0]
        |-> ##[2:4] ready) else $error("slow reinit");
    a_ctrl_zero: assert property (rd && addr == 4'h8 |=> rdata == 32'h0) else $error("ctrl");
    a_scratch_hi: assert property (rd && addr == 4'h4 |=> rdata[31:8] == 24'h0)
        else $error("scratch hi");
    a_unmapped_zero: assert property (rd && addr == 4'hc |=> rdata == 32'h0) else $error("unm");
    a_rdata_hold: assert property (!rd |=> $stable(rdata)) else $error("rdata moved");
endmodule // crc32_props
bind crc32_word_accumulator crc32_props crc32_props_i(.clk(clk), .rst(rst), .sel(sel),
    .write(write), .addr(addr), .wdata(wdata), .rdata(rdata), .ready(ready), .busy(busy));

// ### sim/bus_master.sv
`timescale 1ns/10ps
module bus_master(
    input wire clk,
    input wire ready,
    input wire [31:0] rdata,
    output reg sel,
    output reg write,
    output reg [3:0] addr,
    output reg [31:0] wdata
);
    initial begin
        sel = 1'b0;
        write = 1'b0;
        addr = 4'hf;
        wdata = 32'h0;
    end
    // called at a falling edge; ready is registered, so its value at the falling edge
    // is the one the next rising edge samples
    task xfer(input w, input [3:0] a, input [31:0] d, output [31:0] q);
        begin
            sel = 1'b1;
            write = w;
            addr = a;
            wdata = d;
            while (!ready) @(negedge clk);
            @(posedge clk);
            @(negedge clk);
            q = rdata;
        end
    endtask
    task idle;
        begin
            sel = 1'b0;
            addr = ~addr;
            wdata = ~wdata;
            @(negedge clk);
        end
    endtask
endmodule // bus_master

// ### sim/crc32_word_accumulator_tb_top.sv
`timescale 1ns/10ps
`include "crc32_defs.vh"
module crc32_word_accumulator_tb_top;
    localparam [3:0] dp = `OFS_CHECKSUM_DATA_PORT;
    localparam [3:0] sb = `OFS_SCRATCH_BYTE;
    localparam [3:0] cc = `OFS_CHECKSUM_CONTROL;
    reg clk = 1'b0;
    reg rst = 1'b1;
    wire sel, write, ready, busy;
    wire [3:0] addr;
    wire [31:0] wdata, rdata;
    reg [31:0] q;
    integer err_count = 0, cmp_count = 0;
    initial forever #50 clk = ~clk;
    crc32_word_accumulator crc32_word_accumulator_i(.clk(clk), .rst(rst), .sel(sel),
        .write(write), .addr(addr), .wdata(wdata), .rdata(rdata), .ready(ready), .busy(busy));
    bus_master bus_master_i(.clk(clk), .ready(ready), .rdata(rdata), .sel(sel),
        .write(write), .addr(addr), .wdata(wdata));
    task chk(input string n, input [31:0] s, input [31:0] e);
        begin
            cmp_count = cmp_count + 1;
            if (s !== e) begin
                err_count = err_count + 1;
                $display("mismatch %0s exp %h got %h", n, e, s);
            end
        end
    endtask
    // reference: msb first, no reflection, no final inversion
    function [31:0] nx(input [31:0] c, input [31:0] d);
        integer i;
        begin
            nx = c;
            for (i = 31; i >= 0; i = i - 1)
                nx = {nx[30:0], 1'b0} ^ ((nx[31] ^ d[i]) ? `CRC_POLY : 32'h0);
        end
    endfunction
    task rd(input [3:0] a, input [31:0] e, input string n);
        begin
            bus_master_i.xfer(1'b0, a, 32'h0, q);
            chk(n, q, e);
        end
    endtask
    task wr(input [3:0] a, input [31:0] d);
        bus_master_i.xfer(1'b1, a, d, q);
    endtask
    task t_crc;
        begin
            rd(dp, `CHECKSUM_RESET, "crc");
            rd(sb, 32'h0, "scratch");
            wr(dp, 32'h12345678);
            chk("busy", {31'h0, busy}, 32'h1);
            wr(dp, 32'h80000001);
            rd(dp, nx(nx(`CHECKSUM_RESET, 32'h12345678), 32'h80000001), "crc");
            chk("idle", {31'h0, busy}, 32'h0);
            bus_master_i.idle;
            $display("test crc done");
        end
    endtask
    task t_reinit;
        begin
            wr(sb, 32'h000000a5);
            wr(cc, 32'h1);
            rd(dp, `CHECKSUM_RESET, "crc");
            rd(sb, 32'h000000a5, "scratch");
            rd(cc, 32'h0, "ctrl");
            wr(dp, 32'h0);
            rd(dp, nx(`CHECKSUM_RESET, 32'h0), "crc");
            wr(4'hc, 32'hffffffff);
            rd(4'hc, 32'h0, "unmapped");
            rd(dp, nx(`CHECKSUM_RESET, 32'h0), "crc");
            bus_master_i.idle;
            $display("test reinit done");
        end
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", cmp_count, err_count);
            if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_crc;
        t_reinit;
        summarize;
    end
    initial begin
        #200000;
        err_count = err_count + 1;
        summarize;
    end
endmodule // crc32_word_accumulator_tb_top
